/* src/cbt_map.svh */
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
// ----------------------------------------
// register byte addresses and mask word indices
// ----------------------------------------
`define CBT_MASK_STRIDE    8'h10
`define CBT_WIDX_STD_LOW   2'h0
`define CBT_WIDX_EXT_HIGH  2'h1
`define CBT_WIDX_EXT_LOW   2'h2
`define CBT_OFS_TIMING1    8'h80
`define CBT_OFS_TIMING2    8'h84
`define CBT_OFS_MODE       8'h88
`define CBT_OFS_STATUS     8'h8c
// ----------------------------------------
// field positions
// ----------------------------------------
`define CBT_STD_MSB        7
`define CBT_STD_LSB        5
`define CBT_TOP_MSB        1
`define CBT_TOP_LSB        0
`define CBT_SJW_MSB        7
`define CBT_SJW_LSB        6
`define CBT_BRP_MSB        5
`define CBT_BRP_LSB        0
`define CBT_P2SEL_BIT      7
`define CBT_SAM_BIT        6
`define CBT_PH1_MSB        5
`define CBT_PH1_LSB        3
`define CBT_PROP_MSB       2
`define CBT_PROP_LSB       0
`define CBT_CFG_BIT        0
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define CBT_TIMING_RST     8'h00
`define CBT_MASK_RST       8'h00
`define CBT_MODE_RST       1'b1
`define CBT_IPT_QUANTA     4'h2
`define CBT_SAMPLES_ONE    2'h1
`define CBT_SAMPLES_THREE  2'h3
`endif

/* src/cbt_pkg.sv */
package cbt_pkg;
  typedef logic [7:0] cbt_byte_t;
  typedef logic [2:0] cbt_code_t;
  typedef logic [3:0] cbt_quanta_t;
endpackage : cbt_pkg

/* src/cbt_mask_regs.sv */
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_mask_regs
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rstn,
  // register access
  input  wire logic      wrEn,
  input  wire logic [1:0] wrSel,
  input  wire cbt_byte_t wrData,
  input  wire logic [1:0] rdSel,
  output cbt_byte_t      rdData,
  // mask fields
  output logic [2:0]     stdIdMaskLowBits,
  output logic [1:0]     extIdMaskTopBits,
  output cbt_byte_t      extIdMaskMidBits,
  output cbt_byte_t      extIdMaskLowBits
);
  cbt_byte_t stdLow_r, stdLow_nxt;
  cbt_byte_t extHigh_r, extHigh_nxt;
  cbt_byte_t extLow_r, extLow_nxt;

  always_comb
  begin
    stdLow_nxt  = stdLow_r;
    extHigh_nxt = extHigh_r;
    extLow_nxt  = extLow_r;
    if (wrEn)
    begin
      case (wrSel)
        `CBT_WIDX_STD_LOW:  stdLow_nxt  = wrData & 8'he3;
        `CBT_WIDX_EXT_HIGH: extHigh_nxt = wrData;
        `CBT_WIDX_EXT_LOW:  extLow_nxt  = wrData;
        default:            stdLow_nxt  = stdLow_r;
      endcase
    end
  end

  // power-on content is undefined, zero is one legal choice
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stdLow_r  <= `CBT_MASK_RST;
      extHigh_r <= `CBT_MASK_RST;
      extLow_r  <= `CBT_MASK_RST;
    end
    else
    begin
      stdLow_r  <= stdLow_nxt;
      extHigh_r <= extHigh_nxt;
      extLow_r  <= extLow_nxt;
    end
  end

  always_comb
  begin
    case (rdSel)
      `CBT_WIDX_STD_LOW:  rdData = stdLow_r;
      `CBT_WIDX_EXT_HIGH: rdData = extHigh_r;
      `CBT_WIDX_EXT_LOW:  rdData = extLow_r;
      default:            rdData = 8'h00;
    endcase
  end

  assign stdIdMaskLowBits = stdLow_r[`CBT_STD_MSB:`CBT_STD_LSB];
  assign extIdMaskTopBits = stdLow_r[`CBT_TOP_MSB:`CBT_TOP_LSB];
  assign extIdMaskMidBits = extHigh_r;
  assign extIdMaskLowBits = extLow_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_std_bits;
    (wrEn && wrSel == `CBT_WIDX_STD_LOW) |=> stdIdMaskLowBits == $past(wrData[7:5]);
  endproperty
  a_std_bits: assert property (p_std_bits) else $error("std mask bits lost");
  property p_unimpl_zero;
    (rdSel == `CBT_WIDX_STD_LOW) |-> rdData[4:2] == 3'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits nonzero");
  property p_top_bits;
    (wrEn && wrSel == `CBT_WIDX_STD_LOW) |=> extIdMaskTopBits == $past(wrData[1:0]);
  endproperty
  a_top_bits: assert property (p_top_bits) else $error("ext top bits lost");
  property p_mid_bits;
    (wrEn && wrSel == `CBT_WIDX_EXT_HIGH) ##1 (!wrEn)[*2] |-> extIdMaskMidBits == $past(wrData, 2);
  endproperty
  a_mid_bits: assert property (p_mid_bits) else $error("ext mid bits lost");
  property p_low_bits;
    (wrEn && wrSel == `CBT_WIDX_EXT_LOW) |=> extIdMaskLowBits == $past(wrData);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("ext low bits lost");
endmodule : cbt_mask_regs

/* src/cbt_quantum_gen.sv */
`timescale 1ns/1ps
module cbt_quantum_gen
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // prescaler setting
  input  wire logic [5:0] quantumPrescaler,
  // one pulse per time quantum
  output logic            quantumTick
);
  logic [6:0] cnt_r, cnt_nxt;
  logic       tick_r, tick_nxt;
  logic [6:0] lastCnt;

  // quantum is 2*(field+1) clocks, so the last count is {field,1}
  assign lastCnt = {quantumPrescaler, 1'b1};

  always_comb
  begin
    // >= keeps the counter bounded when the prescaler shrinks
    if (cnt_r >= lastCnt)
    begin
      cnt_nxt  = 7'h00;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt  = cnt_r + 7'h01;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign quantumTick = tick_r;

  // helper: gap since last tick, valid only while the prescaler holds
  logic [6:0] gap_r, gap_nxt;
  logic       clean_r, clean_nxt;
  logic [5:0] presc_r;

  always_comb
  begin
    gap_nxt   = tick_r ? 7'h00 : gap_r + 7'h01;
    clean_nxt = tick_r ? 1'b1 : (clean_r && quantumPrescaler == presc_r);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_r   <= 7'h00;
      clean_r <= 1'b0;
      presc_r <= 6'h00;
    end
    else
    begin
      gap_r   <= gap_nxt;
      clean_r <= clean_nxt;
      presc_r <= quantumPrescaler;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_quantum_period;
    (tick_r && clean_r && $stable(quantumPrescaler)) |-> gap_r == lastCnt;
  endproperty
  a_quantum_period: assert property (p_quantum_period) else $error("quantum period wrong");
endmodule : cbt_quantum_gen

/* src/cbt_config.sv */
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_config
  import cbt_pkg::*;
#(
  parameter int          NUM_MASKS   = 2,
  parameter cbt_quanta_t IPT_QUANTA  = `CBT_IPT_QUANTA
)
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // programmed phase 2 code from the third timing register
  input  wire cbt_code_t              phase2ProgCode,
  // timing outputs
  output logic                        configMode,
  output logic                        quantumTick,
  output logic [2:0]                  jumpQuanta,
  output cbt_quanta_t                 phase1Quanta,
  output cbt_quanta_t                 propQuanta,
  output cbt_quanta_t                 phase2Quanta,
  output logic                        tripleSample,
  output logic [1:0]                  sampleCount,
  // acceptance mask fields, mask n at slice n
  output logic [NUM_MASKS*3-1:0]      stdIdMaskLowBits,
  output logic [NUM_MASKS*2-1:0]      extIdMaskTopBits,
  output logic [NUM_MASKS*8-1:0]      extIdMaskMidBits,
  output logic [NUM_MASKS*8-1:0]      extIdMaskLowBits
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  cbt_byte_t   tim1_r, tim1_nxt;
  cbt_byte_t   tim2_r, tim2_nxt;
  logic        cfg_r, cfg_nxt;
  logic        reqNew;
  logic        wrFire;
  logic [7:0]  wordAdr;
  logic [2:0]  maskIdx;
  logic [1:0]  maskWord;
  logic        isMask;
  logic        isTim1;
  logic        isTim2;
  logic        isMode;
  logic        isStatus;
  cbt_byte_t   maskRd [NUM_MASKS];
  cbt_byte_t   maskRdSel;

  assign reqNew   = wb_cyc_i && wb_stb_i && !ack_r;
  // writes land on the acknowledge edge, when the master samples ack
  assign wrFire   = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
  assign wordAdr  = {wb_adr_i[7:2], 2'b00};
  assign maskIdx  = wb_adr_i[6:4];
  assign maskWord = wb_adr_i[3:2];
  assign isMask   = !wb_adr_i[7] && ({29'h0, maskIdx} < NUM_MASKS) && (maskWord != 2'h3);
  assign isTim1   = wordAdr == `CBT_OFS_TIMING1;
  assign isTim2   = wordAdr == `CBT_OFS_TIMING2;
  assign isMode   = wordAdr == `CBT_OFS_MODE;
  assign isStatus = wordAdr == `CBT_OFS_STATUS;

  // ----------------------------------------
  // mask register banks
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MASKS; gi++)
    begin : g_mask
      cbt_mask_regs u_mask (
        .sys_clk          (sys_clk),
        .rstn             (rstn),
        .wrEn             (wrFire && isMask && maskIdx == 3'(gi)),
        .wrSel            (maskWord),
        .wrData           (wb_dat_i[7:0]),
        .rdSel            (maskWord),
        .rdData           (maskRd[gi]),
        .stdIdMaskLowBits (stdIdMaskLowBits[gi*3 +: 3]),
        .extIdMaskTopBits (extIdMaskTopBits[gi*2 +: 2]),
        .extIdMaskMidBits (extIdMaskMidBits[gi*8 +: 8]),
        .extIdMaskLowBits (extIdMaskLowBits[gi*8 +: 8])
      );
    end
  endgenerate

  always_comb
  begin
    maskRdSel = 8'h00;
    for (int i = 0; i < NUM_MASKS; i++)
    begin
      if (maskIdx == 3'(i))
      begin
        maskRdSel = maskRd[i];
      end
    end
  end

  // ----------------------------------------
  // bus and timing registers
  // ----------------------------------------
  always_comb
  begin
    ack_nxt  = reqNew;
    dat_nxt  = dat_r;
    tim1_nxt = tim1_r;
    tim2_nxt = tim2_r;
    cfg_nxt  = cfg_r;
    if (reqNew)
    begin
      dat_nxt = 32'h0000_0000;
      if (isMask)
      begin
        dat_nxt[7:0] = maskRdSel;
      end
      else if (isTim1 && cfg_r)
      begin
        dat_nxt[7:0] = tim1_r;
      end
      else if (isTim2 && cfg_r)
      begin
        dat_nxt[7:0] = tim2_r;
      end
      else if (isMode)
      begin
        dat_nxt[`CBT_CFG_BIT] = cfg_r;
      end
      else if (isStatus)
      begin
        dat_nxt[3:0] = phase2Quanta;
      end
    end
    if (wrFire)
    begin
      // outside configuration mode timing writes are dropped silently
      if (isTim1 && cfg_r)
      begin
        tim1_nxt = wb_dat_i[7:0];
      end
      if (isTim2 && cfg_r)
      begin
        tim2_nxt = wb_dat_i[7:0];
      end
      if (isMode)
      begin
        cfg_nxt = wb_dat_i[`CBT_CFG_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_r  <= 1'b0;
      dat_r  <= 32'h0000_0000;
      tim1_r <= `CBT_TIMING_RST;
      tim2_r <= `CBT_TIMING_RST;
      cfg_r  <= `CBT_MODE_RST;
    end
    else
    begin
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
      tim1_r <= tim1_nxt;
      tim2_r <= tim2_nxt;
      cfg_r  <= cfg_nxt;
    end
  end

  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = dat_r;
  assign configMode = cfg_r;

  // ----------------------------------------
  // derived segment lengths
  // ----------------------------------------
  logic [2:0]  jump_r, jump_nxt;
  cbt_quanta_t ph1_r, ph1_nxt;
  cbt_quanta_t prop_r, prop_nxt;
  cbt_quanta_t ph2_r, ph2_nxt;
  logic        tri_r, tri_nxt;
  logic [1:0]  cnt_r, cnt_nxt;

  always_comb
  begin
    jump_nxt = {1'b0, tim1_r[`CBT_SJW_MSB:`CBT_SJW_LSB]} + 3'h1;
    ph1_nxt  = {1'b0, tim2_r[`CBT_PH1_MSB:`CBT_PH1_LSB]} + 4'h1;
    prop_nxt = {1'b0, tim2_r[`CBT_PROP_MSB:`CBT_PROP_LSB]} + 4'h1;
    if (tim2_r[`CBT_P2SEL_BIT])
    begin
      ph2_nxt = {1'b0, phase2ProgCode} + 4'h1;
    end
    else if (ph1_nxt > IPT_QUANTA)
    begin
      ph2_nxt = ph1_nxt;
    end
    else
    begin
      ph2_nxt = IPT_QUANTA;
    end
    tri_nxt = tim2_r[`CBT_SAM_BIT];
    cnt_nxt = tri_nxt ? `CBT_SAMPLES_THREE : `CBT_SAMPLES_ONE;
  end

  // registered so the receiver sees one consistent set per clock
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      jump_r <= 3'h1;
      ph1_r  <= 4'h1;
      prop_r <= 4'h1;
      ph2_r  <= IPT_QUANTA;
      tri_r  <= 1'b0;
      cnt_r  <= `CBT_SAMPLES_ONE;
    end
    else
    begin
      jump_r <= jump_nxt;
      ph1_r  <= ph1_nxt;
      prop_r <= prop_nxt;
      ph2_r  <= ph2_nxt;
      tri_r  <= tri_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign jumpQuanta   = jump_r;
  assign phase1Quanta = ph1_r;
  assign propQuanta   = prop_r;
  assign phase2Quanta = ph2_r;
  assign tripleSample = tri_r;
  assign sampleCount  = cnt_r;

  // ----------------------------------------
  // quantum generator
  // ----------------------------------------
  cbt_quantum_gen u_quantum (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .quantumPrescaler (tim1_r[`CBT_BRP_MSB:`CBT_BRP_LSB]),
    .quantumTick      (quantumTick)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_req_start;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_wb_answer;
    s_req_start |=> s_ack_pulse;
  endproperty
  a_wb_answer: assert property (p_wb_answer) else $error("bus answer not one cycle later");

  property p_timing_lock;
    (wrFire && (isTim1 || isTim2) && !cfg_r) |=> $stable(tim1_r) && $stable(tim2_r);
  endproperty
  a_timing_lock: assert property (p_timing_lock) else $error("timing written outside config");
  property p_timing_read_lock;
    (reqNew && !wb_we_i && (isTim1 || isTim2) && !cfg_r) |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_timing_read_lock: assert property (p_timing_read_lock) else $error("timing read outside config");
  property p_timing_write;
    (wrFire && isTim1 && cfg_r) |=> tim1_r == $past(wb_dat_i[7:0]);
  endproperty
  a_timing_write: assert property (p_timing_write) else $error("timing write lost");
  property p_jump;
    $stable(tim1_r) |=> jumpQuanta == {1'b0, $past(tim1_r[7:6])} + 3'h1;
  endproperty
  a_jump: assert property (p_jump) else $error("jump width wrong");
  property p_phase1;
    ##1 phase1Quanta == {1'b0, $past(tim2_r[5:3])} + 4'h1;
  endproperty
  a_phase1: assert property (p_phase1) else $error("phase 1 wrong");
  property p_prop;
    ##1 propQuanta == {1'b0, $past(tim2_r[2:0])} + 4'h1;
  endproperty
  a_prop: assert property (p_prop) else $error("propagation wrong");
  property p_phase2_free;
    tim2_r[7] |=> phase2Quanta == {1'b0, $past(phase2ProgCode)} + 4'h1;
  endproperty
  a_phase2_free: assert property (p_phase2_free) else $error("free phase 2 wrong");
  property p_phase2_max;
    (!tim2_r[7] && $stable(tim2_r)) ##1 $stable(tim2_r)
      |-> phase2Quanta >= phase1Quanta && phase2Quanta >= IPT_QUANTA
          && (phase2Quanta == phase1Quanta || phase2Quanta == IPT_QUANTA);
  endproperty
  a_phase2_max: assert property (p_phase2_max) else $error("derived phase 2 wrong");
  property p_sample;
    ##1 sampleCount == ($past(tim2_r[6]) ? 2'h3 : 2'h1) && tripleSample == $past(tim2_r[6]);
  endproperty
  a_sample: assert property (p_sample) else $error("sample count wrong");
endmodule : cbt_config

/* verif/cbt_bus_node.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far node: measures the quantum period
// ----------------------------------------
module cbt_bus_node
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // quantum pulse from the block
  input  wire logic       quantumTick,
  // last measured gap in clocks
  output logic [7:0]      tickGap
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;

  // gap is the clock count between two ticks, 128 at the longest quantum
  always_comb
  begin
    cnt_nxt = cnt_r + 8'h01;
    gap_nxt = gap_r;
    if (quantumTick)
    begin
      gap_nxt = cnt_r + 8'h01;
      cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 8'h00;
      gap_r <= 8'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
    end
  end

  assign tickGap = gap_r;
endmodule : cbt_bus_node

/* verif/cbt_config_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module cbt_config_tb;
  import cbt_pkg::*;
  logic        sys_clk, rstn, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI, datO, rd;
  cbt_code_t   p2Code;
  logic        configMode, quantumTick, tripleSample;
  logic [2:0]  jumpQuanta;
  cbt_quanta_t ph1Q, propQ, ph2Q;
  logic [1:0]  sampleCount;
  logic [5:0]  stdM;
  logic [3:0]  topM;
  logic [15:0] midM, lowM;
  logic [7:0]  tickGap;
  int          n_fail, check_count;

  cbt_config u_cbt_config (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .phase2ProgCode(p2Code), .configMode(configMode), .quantumTick(quantumTick), .jumpQuanta(jumpQuanta),
    .phase1Quanta(ph1Q), .propQuanta(propQ), .phase2Quanta(ph2Q), .tripleSample(tripleSample),
    .sampleCount(sampleCount), .stdIdMaskLowBits(stdM), .extIdMaskTopBits(topM),
    .extIdMaskMidBits(midM), .extIdMaskLowBits(lowM));
  cbt_bus_node u_cbt_bus_node (.sys_clk(sys_clk), .rstn(rstn), .quantumTick(quantumTick), .tickGap(tickGap));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // bus helpers
  // ----------------------------------------
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= {24'h000000, d}; sel <= s;
    // no limit of its own: the watchdog ends a hung wait
    do
    begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    rd = datO;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    // one idle cycle so the request is not taken twice
    @(posedge sys_clk);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_xfer(1'b1, a, d, 4'hf);
    repeat (2) @(posedge sys_clk);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    wb_xfer(1'b0, a, 8'h00, 4'hf);
    `CHK(nm, {24'h000000, ex}, rd)
  endtask : rd_chk

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd_chk("mode", 8'h88, 8'h01);
    rd_chk("timing1", 8'h80, 8'h00);
    rd_chk("timing2", 8'h84, 8'h00);
    rd_chk("status", 8'h8c, 8'h02);
    `CHK("jump", 3'h1, jumpQuanta)
    `CHK("ph1", 4'h1, ph1Q)
    `CHK("prop", 4'h1, propQ)
    `CHK("count", 2'h1, sampleCount)
  endtask : t_reset

  task automatic t_masks;
    logic [7:0] d;
    for (int m = 0; m < 2; m++)
    begin
      d = m ? 8'h5e : 8'hbd;
      wr(8'(m * 16), d);
      wr(8'(m * 16 + 4), 8'ha5 + 8'(m));
      wr(8'(m * 16 + 8), 8'h3c + 8'(m));
      rd_chk("stdlow", 8'(m * 16), d & 8'he3);
      `CHK("stdbits", d[7:5], stdM[m*3+:3])
      `CHK("topbits", d[1:0], topM[m*2+:2])
      `CHK("midbits", 8'ha5 + 8'(m), midM[m*8+:8])
      `CHK("lowbits", 8'h3c + 8'(m), lowM[m*8+:8])
    end
  endtask : t_masks

  task automatic t_prescale;
    logic [7:0] v [3] = '{8'hc3, 8'h3f, 8'h80};
    int gap;
    foreach (v[i])
    begin
      wr(8'h80, v[i]);
      gap = 2 * (int'(v[i][5:0]) + 1);
      repeat (2 * gap + 10) @(posedge sys_clk);
      `CHK("jump", 3'(v[i][7:6]) + 3'h1, jumpQuanta)
      `CHK("tickgap", 8'(gap), tickGap)
    end
  endtask : t_prescale

  task automatic t_segments;
    logic [7:0] v [3] = '{8'hff, 8'h12, 8'h02};
    logic [3:0] p1, p2;
    p2Code <= 3'h5;
    foreach (v[i])
    begin
      wr(8'h84, v[i]);
      p1 = 4'(v[i][5:3]) + 4'h1;
      p2 = v[i][7] ? 4'h6 : ((p1 > 4'h2) ? p1 : 4'h2);
      `CHK("ph1", p1, ph1Q)
      `CHK("prop", 4'(v[i][2:0]) + 4'h1, propQ)
      `CHK("ph2", p2, ph2Q)
      `CHK("triple", v[i][6], tripleSample)
      `CHK("count", v[i][6] ? 2'h3 : 2'h1, sampleCount)
      rd_chk("status", 8'h8c, {4'h0, p2});
    end
  endtask : t_segments

  task automatic t_locked;
    wr(8'h88, 8'h00);
    `CHK("cfgmode", 1'b0, configMode)
    wr(8'h80, 8'h55);
    rd_chk("timing1", 8'h80, 8'h00);
    `CHK("jump", 3'h3, jumpQuanta)
    wr(8'h84, 8'hff);
    rd_chk("timing2", 8'h84, 8'h00);
    `CHK("ph1", 4'h1, ph1Q)
    // software re-enters configuration before touching timing again
    wr(8'h88, 8'h01);
    rd_chk("timing1", 8'h80, 8'h80);
    rd_chk("timing2", 8'h84, 8'h02);
  endtask : t_locked

  task automatic t_misc;
    rd_chk("unmapped", 8'h30, 8'h00);
    wb_xfer(1'b1, 8'h04, 8'h11, 4'he);
    rd_chk("nosel", 8'h04, 8'ha5);
  endtask : t_misc

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  initial
  begin
    #200000;
    n_fail++;
    close_out;
  end

  initial
  begin
    n_fail = 0; check_count = 0;
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'h0; datI = 32'h0; p2Code = 3'h0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_masks;
    t_prescale;
    t_segments;
    t_locked;
    t_misc;
    close_out;
  end
endmodule : cbt_config_tb
